// >>> common/rcl_pkg.sv
// Constants, field layouts and state carriers for the calendar clock control block
package rcl_pkg;

   // Register byte offsets
   localparam logic [4:0]  RCL_OFS_CONTROL  = 5'h00;
   localparam logic [4:0]  RCL_OFS_TIME     = 5'h04;
   localparam logic [4:0]  RCL_OFS_UNLOCK   = 5'h08;
   localparam logic [4:0]  RCL_OFS_IRQ_STAT = 5'h0C;
   localparam logic [4:0]  RCL_OFS_IRQ_MASK = 5'h10;
   localparam logic [4:0]  RCL_OFS_ALARM    = 5'h14;

   // rtc_control field positions
   localparam int RCL_POS_ON      = 15;
   localparam int RCL_POS_CLKSEL  = 9;
   localparam int RCL_POS_OUTSEL  = 7;
   localparam int RCL_POS_RUNNING = 6;
   localparam int RCL_POS_WREN    = 3;
   localparam int RCL_POS_SYNC    = 2;
   localparam int RCL_POS_HALF_SECOND_STATUS = 1;
   localparam int RCL_POS_OE      = 0;
   localparam int RCL_POS_SECONDS = 8;

   // Field encodings
   localparam logic [1:0]  RCL_CLK_INTERNAL_LOW_POWER_OSCILLATOR      = 2'h0;
   localparam logic [1:0]  RCL_CLK_SECONDARY_OSCILLATOR      = 2'h1;
   localparam logic [1:0]  RCL_OUT_ALARM     = 2'h0;
   localparam logic [1:0]  RCL_OUT_SECONDS   = 2'h1;
   localparam logic [1:0]  RCL_OUT_CLOCK     = 2'h2;

   // Unlock keys, arbitrary values
   localparam logic [31:0] RCL_KEY_FIRST     = 32'h0000_A5C3;
   localparam logic [31:0] RCL_KEY_SECOND    = 32'h0000_3C5A;

   // Prescaler: oscillator edges per second and read-sync window
   localparam logic [14:0] RCL_PRESC_LAST    = 15'h7FFF;
   localparam logic [14:0] RCL_PRESC_SYNC    = 15'h7FE0;
   localparam logic [6:0]  RCL_SECS_LAST     = 7'h3B;

   // Clock-running timeout
   localparam int          RCL_CLK_MHZ       = 200;
   localparam int          RCL_RUN_TIMEOUT_US = 100;
   localparam int          RCL_RUN_TIMEOUT_CYC = RCL_RUN_TIMEOUT_US * RCL_CLK_MHZ;

   // Interrupt status bits
   localparam int RCL_IRQ_ALARM  = 0;
   localparam int RCL_IRQ_SECOND = 1;

   typedef enum logic [2:0]
   {
      RCL_LOCKED = 3'b001,
      RCL_KEY1   = 3'b010,
      RCL_OPEN   = 3'b100
   } rcl_unlock_e;

   typedef struct packed
   {
      logic       on;
      logic [1:0] clksel;
      logic [1:0] outsel;
      logic       wren;
      logic       oe;
   } rcl_ctl_s;

   typedef struct packed
   {
      logic s1;
      logic s2;
   } rcl_sync_s;

   typedef struct packed
   {
      rcl_ctl_s    ctl;
      rcl_unlock_e unlock;
      logic [14:0] presc;
      logic [6:0]  secs;
      logic [6:0]  alarm_secs;
      logic        running;
      logic [15:0] run_cnt;
      logic [1:0]  irq_stat;
      logic [1:0]  irq_mask;
      logic        alarm_hold;
      logic        secondary_oscillator_prev;
      logic        internal_low_power_oscillator_prev;
      logic        wait_r;
      logic [31:0] rdata;
      logic        pin;
      logic        irq;
   } rcl_state_s;

endpackage : rcl_pkg

// >>> hdl/rcl_sync2.sv
// Two-stage synchroniser for an oscillator pin
`timescale 1ns/100ps
`default_nettype none
module rcl_sync2
   import rcl_pkg::*;
(
   input  wire logic mclk,
   input  wire logic reset,
   input  wire logic d,
   output logic      q
);
   rcl_sync_s st_r;
   rcl_sync_s st_nxt;

   always_comb
   begin
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign q = st_r.s2;
endmodule : rcl_sync2
`default_nettype wire

// >>> hdl/rcl_control.sv
// Calendar clock control: source select, unlock, prescaler, status and output pin
// Function
// - clock source 01 secondary, 00 internal oscillator
// - output select: clock, seconds clock, alarm
// - pin active only while output enabled
// - running status shows oscillator activity
// - time writes need value write enable
// - write enable set only when unlocked
// - on bit writable only with write enable
// - read sync flags possible rollover ripple
// - half-second bit high in second half
// - seconds write clears half-second bit
// - output enable bit gates pin function
// - control register reset by power-on only
`timescale 1ns/100ps
`default_nettype none
module rcl_control
   import rcl_pkg::*;
#(
   parameter int unsigned RUN_TIMEOUT_CYC = RCL_RUN_TIMEOUT_CYC
)
(
   input  wire logic        mclk,
   input  wire logic        reset,
   input  wire logic        soft_reset,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        secondary_oscillator_in,
   input  wire logic        internal_low_power_oscillator_in,
   output logic             rtc_pin_out,
   output logic             rtc_pin_oe,
   output logic             irq
);

   localparam logic [15:0] RUN_LIMIT = 16'(RUN_TIMEOUT_CYC - 1);

   rcl_state_s  st_r;
   rcl_state_s  st_nxt;
   logic        secondary_oscillator_q;
   logic        internal_low_power_oscillator_q;
   logic        secondary_oscillator_edge;
   logic        internal_low_power_oscillator_edge;
   logic        sel_edge;
   logic        sel_level;
   logic        half_tick;
   logic        sec_tick;
   logic        wr_go;
   logic        rd_go;
   logic        half_second_status;
   logic        sync_flag;
   logic [31:0] ctl_word;
   logic [31:0] bmask;
   logic [31:0] merged;
   logic        alarm_evt;

   rcl_sync2 u_sync_secondary_oscillator
   (
      .mclk  (mclk),
      .reset (reset),
      .d     (secondary_oscillator_in),
      .q     (secondary_oscillator_q)
   );

   rcl_sync2 u_sync_internal_low_power_oscillator
   (
      .mclk  (mclk),
      .reset (reset),
      .d     (internal_low_power_oscillator_in),
      .q     (internal_low_power_oscillator_q)
   );

   assign secondary_oscillator_edge = secondary_oscillator_q & ~st_r.secondary_oscillator_prev;
   assign internal_low_power_oscillator_edge = internal_low_power_oscillator_q & ~st_r.internal_low_power_oscillator_prev;

   always_comb
   begin
      // Reserved codes select nothing, so the clock reads as stopped
      case (st_r.ctl.clksel)
         RCL_CLK_SECONDARY_OSCILLATOR:
         begin
            sel_edge  = secondary_oscillator_edge;
            sel_level = secondary_oscillator_q;
         end
         RCL_CLK_INTERNAL_LOW_POWER_OSCILLATOR:
         begin
            sel_edge  = internal_low_power_oscillator_edge;
            sel_level = internal_low_power_oscillator_q;
         end
         default:
         begin
            sel_edge  = 1'b0;
            sel_level = 1'b0;
         end
      endcase
   end

   assign half_second_status   = st_r.presc[14];
   assign half_tick = st_r.ctl.on & sel_edge & (st_r.presc[13:0] == 14'h3FFF);
   assign sec_tick  = half_tick & (st_r.presc == RCL_PRESC_LAST);
   // Ripple window: last edges before the seconds count rolls
   assign sync_flag = st_r.ctl.on & (st_r.presc >= RCL_PRESC_SYNC);
   assign alarm_evt = sec_tick & (((st_r.secs == RCL_SECS_LAST) ? 7'h00 :
                                   7'(st_r.secs + 7'h01)) == st_r.alarm_secs);

   assign wr_go = avs_write & ~st_r.wait_r;
   assign rd_go = avs_read & st_r.wait_r;

   always_comb
   begin
      ctl_word                  = '0;
      ctl_word[RCL_POS_ON]      = st_r.ctl.on;
      ctl_word[RCL_POS_CLKSEL +: 2] = st_r.ctl.clksel;
      ctl_word[RCL_POS_OUTSEL +: 2] = st_r.ctl.outsel;
      ctl_word[RCL_POS_RUNNING] = st_r.running;
      ctl_word[RCL_POS_WREN]    = st_r.ctl.wren;
      ctl_word[RCL_POS_SYNC]    = sync_flag;
      ctl_word[RCL_POS_HALF_SECOND_STATUS] = half_second_status;
      ctl_word[RCL_POS_OE]      = st_r.ctl.oe;
      bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
               {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
      case (avs_address)
         RCL_OFS_CONTROL: merged = ctl_word;
         RCL_OFS_TIME:    merged = {17'h0, st_r.secs, 8'h00};
         RCL_OFS_ALARM:   merged = {17'h0, st_r.alarm_secs, 8'h00};
         default:         merged = '0;
      endcase
      merged = (merged & ~bmask) | (avs_writedata & bmask);
   end

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.secondary_oscillator_prev = secondary_oscillator_q;
      st_nxt.internal_low_power_oscillator_prev = internal_low_power_oscillator_q;

      // Clock-running watchdog on the selected source
      if (sel_edge)
      begin
         st_nxt.run_cnt = '0;
         st_nxt.running = 1'b1;
      end
      else if (st_r.run_cnt >= RUN_LIMIT)
         st_nxt.running = 1'b0;
      else
         st_nxt.run_cnt = st_r.run_cnt + 16'h0001;

      // Prescaler and seconds count
      if (st_r.ctl.on & sel_edge)
         st_nxt.presc = st_r.presc + 15'h0001;
      if (sec_tick)
         st_nxt.secs = (st_r.secs == RCL_SECS_LAST) ? 7'h00 : 7'(st_r.secs + 7'h01);

      // Alarm pulse lasts until the next half-second boundary
      if (alarm_evt)
         st_nxt.alarm_hold = 1'b1;
      else if (half_tick)
         st_nxt.alarm_hold = 1'b0;

      // Avalon handshake: one wait cycle, then answer
      st_nxt.wait_r = ~((avs_read | avs_write) & st_r.wait_r);
      if (rd_go)
      begin
         case (avs_address)
            RCL_OFS_CONTROL:  st_nxt.rdata = ctl_word;
            RCL_OFS_TIME:     st_nxt.rdata = {17'h0, st_r.secs, 8'h00};
            RCL_OFS_UNLOCK:   st_nxt.rdata = {31'h0, st_r.unlock == RCL_OPEN};
            RCL_OFS_IRQ_STAT: st_nxt.rdata = {30'h0, st_r.irq_stat};
            RCL_OFS_IRQ_MASK: st_nxt.rdata = {30'h0, st_r.irq_mask};
            RCL_OFS_ALARM:    st_nxt.rdata = {17'h0, st_r.alarm_secs, 8'h00};
            default:          st_nxt.rdata = '0;
         endcase
      end

      if (wr_go)
      begin
         case (avs_address)
            RCL_OFS_CONTROL:
            begin
               st_nxt.ctl.clksel = merged[RCL_POS_CLKSEL +: 2];
               st_nxt.ctl.outsel = merged[RCL_POS_OUTSEL +: 2];
               st_nxt.ctl.oe     = merged[RCL_POS_OE];
               if (st_r.ctl.wren)
                  st_nxt.ctl.on = merged[RCL_POS_ON];
               if (!merged[RCL_POS_WREN] || st_r.unlock == RCL_OPEN)
                  st_nxt.ctl.wren = merged[RCL_POS_WREN];
            end
            RCL_OFS_TIME:
            begin
               // Seconds write restarts the prescaler, which is how a new
               // source selection gets a clean start
               if (st_r.ctl.wren)
               begin
                  st_nxt.secs  = merged[RCL_POS_SECONDS +: 7];
                  st_nxt.presc = '0;
               end
            end
            RCL_OFS_UNLOCK:
            begin
               case (st_r.unlock)
                  RCL_LOCKED:
                     st_nxt.unlock = (avs_writedata == RCL_KEY_FIRST) ? RCL_KEY1 : RCL_LOCKED;
                  RCL_KEY1:
                     st_nxt.unlock = (avs_writedata == RCL_KEY_SECOND) ? RCL_OPEN : RCL_LOCKED;
                  default:
                     st_nxt.unlock = RCL_LOCKED;
               endcase
            end
            RCL_OFS_IRQ_MASK:
               st_nxt.irq_mask = merged[1:0];
            RCL_OFS_ALARM:
               st_nxt.alarm_secs = merged[RCL_POS_SECONDS +: 7];
            default:
               st_nxt.irq_mask = st_r.irq_mask;
         endcase
      end

      // Sticky status: write-one clears, a new event wins
      st_nxt.irq_stat = st_r.irq_stat;
      if (wr_go && avs_address == RCL_OFS_IRQ_STAT && avs_byteenable[0])
         st_nxt.irq_stat = st_r.irq_stat & ~avs_writedata[1:0];
      st_nxt.irq_stat[RCL_IRQ_ALARM]  = st_nxt.irq_stat[RCL_IRQ_ALARM] | alarm_evt;
      st_nxt.irq_stat[RCL_IRQ_SECOND] = st_nxt.irq_stat[RCL_IRQ_SECOND] | sec_tick;
      st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);

      // Output pin source
      if (!st_r.ctl.oe)
         st_nxt.pin = 1'b0;
      else
      begin
         case (st_r.ctl.outsel)
            RCL_OUT_CLOCK:   st_nxt.pin = sel_level;
            RCL_OUT_SECONDS: st_nxt.pin = half_second_status;
            RCL_OUT_ALARM:   st_nxt.pin = st_r.alarm_hold;
            default:         st_nxt.pin = 1'b0;
         endcase
      end

      // Other resets spare the control register and timekeeping
      if (soft_reset)
      begin
         st_nxt.unlock     = RCL_LOCKED;
         st_nxt.irq_stat   = '0;
         st_nxt.irq_mask   = '0;
         st_nxt.irq        = 1'b0;
         st_nxt.alarm_hold = 1'b0;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         st_r        <= '0;
         st_r.unlock <= RCL_LOCKED;
         st_r.wait_r <= 1'b1;
      end
      else
         st_r <= st_nxt;
   end

   assign avs_readdata    = st_r.rdata;
   assign avs_waitrequest = st_r.wait_r;
   assign rtc_pin_out     = st_r.pin;
   assign rtc_pin_oe      = st_r.ctl.oe;
   assign irq             = st_r.irq;

   property p_src_secondary_oscillator;
      @(posedge mclk) disable iff (reset)
      (st_r.ctl.clksel == RCL_CLK_SECONDARY_OSCILLATOR && st_r.ctl.on && secondary_oscillator_edge) |=>
         (st_r.presc == 15'($past(st_r.presc) + 15'h0001)) || $past(wr_go);
   endproperty
   a_src_secondary_oscillator: assert property (p_src_secondary_oscillator) else $error("secondary edge not counted");

   property p_pin_off;
      @(posedge mclk) disable iff (reset)
      !st_r.ctl.oe |=> !rtc_pin_out;
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("pin active while disabled");

   property p_pin_seconds;
      @(posedge mclk) disable iff (reset)
      (st_r.ctl.oe && st_r.ctl.outsel == RCL_OUT_SECONDS) |=> rtc_pin_out == $past(half_second_status);
   endproperty
   a_pin_seconds: assert property (p_pin_seconds) else $error("seconds clock not on pin");

   property p_running_edge;
      @(posedge mclk) disable iff (reset)
      sel_edge |=> st_r.running ##1 (st_r.running || $past(st_r.run_cnt) >= RUN_LIMIT);
   endproperty
   a_running_edge: assert property (p_running_edge) else $error("running not set on edge");

   property p_time_locked;
      @(posedge mclk) disable iff (reset)
      (wr_go && avs_address == RCL_OFS_TIME && !st_r.ctl.wren && !sec_tick) |=>
         $stable(st_r.secs);
   endproperty
   a_time_locked: assert property (p_time_locked) else $error("locked time write took");

   property p_wren_unlock;
      @(posedge mclk) disable iff (reset)
      $rose(st_r.ctl.wren) |-> $past(st_r.unlock) == RCL_OPEN;
   endproperty
   a_wren_unlock: assert property (p_wren_unlock) else $error("write enable set while locked");

   property p_on_gate;
      @(posedge mclk) disable iff (reset)
      $changed(st_r.ctl.on) |-> $past(st_r.ctl.wren);
   endproperty
   a_on_gate: assert property (p_on_gate) else $error("on bit changed without enable");

   property p_sync_window;
      @(posedge mclk) disable iff (reset)
      (rd_go && avs_address == RCL_OFS_CONTROL && st_r.ctl.on &&
       st_r.presc >= RCL_PRESC_SYNC) |=> avs_readdata[RCL_POS_SYNC];
   endproperty
   a_sync_window: assert property (p_sync_window) else $error("sync flag missing");

   property p_sec_clear;
      @(posedge mclk) disable iff (reset)
      (wr_go && avs_address == RCL_OFS_TIME && st_r.ctl.wren) |=> !half_second_status;
   endproperty
   a_sec_clear: assert property (p_sec_clear) else $error("half-second not cleared");

   sequence s_half_tick;
      half_tick && !wr_go;
   endsequence
   property p_half_toggle;
      @(posedge mclk) disable iff (reset)
      s_half_tick |=> half_second_status != $past(half_second_status);
   endproperty
   a_half_toggle: assert property (p_half_toggle) else $error("half-second not toggled");

   property p_soft_keep;
      @(posedge mclk) disable iff (reset)
      (soft_reset && !wr_go) |=> $stable(st_r.ctl);
   endproperty
   a_soft_keep: assert property (p_soft_keep) else $error("control lost on soft reset");

endmodule : rcl_control
`default_nettype wire

// >>> testbench/rcl_osc_model.sv
// Behavioural oscillators and pin load at the far side of the control block
`timescale 1ns/100ps
`default_nettype none
module rcl_osc_model
(
   input  wire logic secondary_oscillator_run,
   input  wire logic internal_low_power_oscillator_run,
   input  wire logic rtc_pin_out,
   input  wire logic rtc_pin_oe,
   output logic      secondary_oscillator_in,
   output logic      internal_low_power_oscillator_in,
   output logic      pin_level
);
   // Far faster than 32 kHz so a whole second fits the run
   initial
   begin
      secondary_oscillator_in = 1'b0;
      internal_low_power_oscillator_in = 1'b0;
      #1.3;
      forever
      begin
         #5;
         secondary_oscillator_in = secondary_oscillator_run ? ~secondary_oscillator_in : 1'b0;
         internal_low_power_oscillator_in = internal_low_power_oscillator_run ? ~internal_low_power_oscillator_in : 1'b0;
      end
   end
   // Pull-down on the pin while it is not driven
   assign pin_level = rtc_pin_oe ? rtc_pin_out : 1'b0;
endmodule : rcl_osc_model
`default_nettype wire

// >>> testbench/rcl_control_test.sv
// Self-checking bench for the calendar clock control block
`timescale 1ns/100ps
`default_nettype none
module rcl_control_test
   import rcl_pkg::*;
;
   localparam int RUN_TO = 64;
   logic        mclk, reset, soft_reset, avs_read, avs_write;
   logic [4:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, rdq, rdp;
   logic        avs_waitrequest, secondary_oscillator_in, internal_low_power_oscillator_in, rtc_pin_out, rtc_pin_oe, irq;
   logic        secondary_oscillator_run, internal_low_power_oscillator_run, pin_level;
   int          e_on, e_clk, e_wren, e_open, secs, t0, n;
   int          seed = 76;
   int          fail_count = 0;
   int          cmp_count = 0;
   int          cyc = 0;

   rcl_control #(.RUN_TIMEOUT_CYC(RUN_TO)) i_rcl_control
   (
      .mclk(mclk), .reset(reset), .soft_reset(soft_reset), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .secondary_oscillator_in(secondary_oscillator_in), .internal_low_power_oscillator_in(internal_low_power_oscillator_in),
      .rtc_pin_out(rtc_pin_out), .rtc_pin_oe(rtc_pin_oe), .irq(irq)
   );
   rcl_osc_model i_rcl_osc_model
   (
      .secondary_oscillator_run(secondary_oscillator_run), .internal_low_power_oscillator_run(internal_low_power_oscillator_run), .rtc_pin_out(rtc_pin_out),
      .rtc_pin_oe(rtc_pin_oe), .secondary_oscillator_in(secondary_oscillator_in), .internal_low_power_oscillator_in(internal_low_power_oscillator_in), .pin_level(pin_level)
   );

   task automatic finish_test();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test

   task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp, input string s);
      cmp_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD %0t %s got %h exp %h", $time, s, got, exp);
      end
   endtask : cmp_reg

   task automatic cmp_pin(input logic got, input logic exp, input string s);
      cmp_reg({31'h0, got}, {31'h0, exp}, s);
   endtask : cmp_pin

   // Request held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge mclk);
      avs_address   <= a;
      avs_write     <= wr;
      avs_read      <= ~wr;
      avs_writedata <= d;
      do
         @(posedge mclk);
      while (avs_waitrequest !== 1'b0);
      rdq = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   function automatic logic [31:0] exp_ctl(input int out, input int oe);
      return 32'(e_on * 32768 + e_clk * 512 + out * 128 + e_wren * 8 + oe);
   endfunction : exp_ctl

   task automatic wr_ctl(input int on, input int clk, input int out, input int wr,
                         input int oe);
      if (e_wren != 0)
         e_on = on;
      e_wren = (e_open != 0) ? wr : (e_wren & wr);
      e_clk = clk;
      bus(1'b1, RCL_OFS_CONTROL, 32'(on * 32768 + clk * 512 + out * 128 + wr * 8 + oe));
      bus(1'b0, RCL_OFS_CONTROL, 32'h0);
      cmp_reg(rdq & 32'h0000_8789, exp_ctl(out, oe), "control fields");
   endtask : wr_ctl

   task automatic count_pin();
      n = 0;
      repeat (20) @(posedge mclk) n += pin_level;
   endtask : count_pin

   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // Hang guard just above the three half-second waits the run needs
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 99500)
      begin
         fail_count++;
         finish_test();
      end
   end

   initial
   begin
      reset = 1'b1;
      soft_reset = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 5'h00;
      avs_writedata = 32'h0;
      secondary_oscillator_run = 1'b1;
      internal_low_power_oscillator_run = 1'b0;
      {e_on, e_clk, e_wren, e_open} = '0;
      repeat (4) @(posedge mclk);
      reset <= 1'b0;
      bus(1'b0, RCL_OFS_CONTROL, 32'h0);
      cmp_reg(rdq & 32'h0000_8789, 32'h0, "control after reset");
      cmp_pin(rtc_pin_oe, 1'b0, "oe after reset");
      wr_ctl(1, 1, 2, 1, 0);
      bus(1'b1, RCL_OFS_TIME, 32'h0000_1500);
      bus(1'b0, RCL_OFS_TIME, 32'h0);
      cmp_reg(rdq & 32'h0000_7F00, 32'h0, "time locked");
      bus(1'b1, 5'h18, $random(seed));
      bus(1'b0, 5'h18, 32'h0);
      cmp_reg(rdq, 32'h0, "unmapped");
      $display("test locked done");
      bus(1'b1, RCL_OFS_UNLOCK, RCL_KEY_FIRST);
      bus(1'b1, RCL_OFS_UNLOCK, RCL_KEY_SECOND);
      e_open = 1;
      wr_ctl(0, 1, 2, 1, 0);
      wr_ctl(1, 1, 2, 1, 0);
      // Last pass repeats code 00 with the internal source started
      for (int c = 0; c < 5; c++)
      begin
         internal_low_power_oscillator_run <= (c == 4);
         wr_ctl(1, c % 4, 2, 1, 0);
         bus(1'b1, RCL_OFS_TIME, 32'h0);
         repeat (RUN_TO + 20) @(posedge mclk);
         bus(1'b0, RCL_OFS_CONTROL, 32'h0);
         cmp_pin(rdq[6], (c == 1 || c == 4), "running");
      end
      $display("test source done");
      wr_ctl(1, 1, 2, 1, 0);
      count_pin();
      cmp_pin(n == 0, 1'b1, "pin disabled");
      wr_ctl(1, 1, 2, 1, 1);
      count_pin();
      cmp_pin(n > 4 && n < 16, 1'b1, "raw clock on pin");
      cmp_pin(rtc_pin_oe, 1'b1, "oe set");
      wr_ctl(1, 1, 3, 1, 1);
      count_pin();
      cmp_pin(n == 0, 1'b1, "reserved output");
      $display("test pin done");
      wr_ctl(1, 1, 1, 1, 1);
      secs = ($random(seed) & 32'h1F) + 5;
      bus(1'b1, RCL_OFS_TIME, 32'(secs << 8));
      t0 = cyc;
      bus(1'b0, RCL_OFS_CONTROL, 32'h0);
      cmp_pin(rdq[1], 1'b0, "half cleared");
      while (pin_level !== 1'b1) @(posedge mclk);
      cmp_pin((cyc - t0) > 32760 && (cyc - t0) < 32800, 1'b1, "half time");
      bus(1'b0, RCL_OFS_CONTROL, 32'h0);
      cmp_pin(rdq[1], 1'b1, "second half");
      // Seconds write in the second half must pull the bit back down
      bus(1'b1, RCL_OFS_TIME, 32'(secs << 8));
      bus(1'b0, RCL_OFS_CONTROL, 32'h0);
      cmp_pin(rdq[1], 1'b0, "half cleared late");
      $display("test half done");
      bus(1'b1, RCL_OFS_ALARM, 32'((secs + 1) << 8));
      wr_ctl(1, 1, 0, 1, 1);
      while (rdq[2] !== 1'b1) bus(1'b0, RCL_OFS_CONTROL, 32'h0);
      // Read twice before trusting the value
      bus(1'b0, RCL_OFS_TIME, 32'h0);
      rdp = rdq;
      bus(1'b0, RCL_OFS_TIME, 32'h0);
      cmp_reg(rdq, rdp, "double read");
      cmp_reg(rdq & 32'h0000_7F00, 32'(secs << 8), "time before roll");
      cmp_pin(pin_level, 1'b0, "no alarm yet");
      while (pin_level !== 1'b1) @(posedge mclk);
      bus(1'b0, RCL_OFS_TIME, 32'h0);
      cmp_reg(rdq & 32'h0000_7F00, 32'((secs + 1) << 8), "time after roll");
      bus(1'b0, RCL_OFS_IRQ_STAT, 32'h0);
      cmp_reg(rdq & 32'h0000_0003, 32'h3, "irq status");
      cmp_pin(irq, 1'b0, "irq masked");
      bus(1'b1, RCL_OFS_IRQ_MASK, 32'h0000_0001);
      repeat (3) @(posedge mclk);
      cmp_pin(irq, 1'b1, "irq raised");
      bus(1'b1, RCL_OFS_IRQ_STAT, 32'h0000_0003);
      repeat (3) @(posedge mclk);
      cmp_pin(irq, 1'b0, "irq cleared");
      $display("test alarm done");
      soft_reset <= 1'b1;
      @(posedge mclk);
      soft_reset <= 1'b0;
      e_open = 0;
      bus(1'b0, RCL_OFS_CONTROL, 32'h0);
      cmp_reg(rdq & 32'h0000_8789, exp_ctl(0, 1), "control kept");
      wr_ctl(1, 1, 0, 1, 1);
      wr_ctl(1, 1, 0, 0, 1);
      wr_ctl(1, 1, 0, 1, 1);
      $display("test soft reset done");
      finish_test();
   end
endmodule : rcl_control_test
`default_nettype wire
